// ### logic/tg_counter.sv
// Purpose: the 16-bit count pair with wrap detection
// Assumes: load and inc never wanted together; load wins
// Notes:   wrap pulses in the same cycle in which the count returns to zero
`timescale 1ns/1ps
`default_nettype none
module tg_counter (
  input  wire logic clk_i,
  input  wire logic rst_i,
  tg_cnt_if.cnt     bus
);
  import tg_pkg::*;

  logic [COUNT_W-1:0] count_reg;
  logic               wrap_reg;
  wire  logic         at_max = (count_reg == {COUNT_W{1'b1}});

  // count up, wrap from all ones to zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_reg <= COUNT_RST;
      wrap_reg  <= 1'b0;
    end else if (bus.load) begin
      count_reg <= bus.load_val;
      wrap_reg  <= 1'b0;
    end else begin
      if (bus.inc) begin
        count_reg <= count_reg + COUNT_W'(1);
      end
      wrap_reg <= bus.inc & at_max;
    end
  end

  assign bus.count = count_reg;
  assign bus.wrap  = wrap_reg;
endmodule
`default_nettype wire

// ### logic/tg_gate_top.sv
// Purpose: gate control, gate value, gate event and rollover flags of a 16-bit timer
// Assumes: gate and external count pins are asynchronous; 8-bit timer count is on clk_i
// Notes:   registers over classic Wishbone, single-cycle registered ack
//          ack follows a taken request by one clock; no wait states
//
// Implementation choices: the register addresses and the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
module tg_gate_top (
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  // wishbone slave
  input  wire logic                  wb_cyc_i,
  input  wire logic                  wb_stb_i,
  input  wire logic                  wb_we_i,
  input  wire logic [7:0]            wb_adr_i,
  input  wire logic [3:0]            wb_sel_i,
  input  wire logic [31:0]           wb_dat_i,
  output logic      [31:0]           wb_dat_o,
  output logic                       wb_ack_o,
  // pins and neighbours
  input  wire logic                  gate_input_pin_i,
  input  wire logic                  ext_count_pin_i,
  input  wire logic [tg_pkg::PRE_W-1:0] t8_count_i,
  input  wire logic                  sleep_i,
  // results
  output logic                       rollover_irq_o,
  output logic                       gate_irq_o,
  output logic                       wake_o,
  output logic                       osc_run_o,
  output logic                       gate_level_o
);
  import tg_pkg::*;

  // the count pair sits in its own module; this controller only steers inc and load
  // and watches the wrap pulse, so the counter stays small and easy to check alone
  tg_cnt_if #(.WIDTH(COUNT_W)) cnt_bus ();

  tg_counter i_tg_counter (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .bus   (cnt_bus)
  );

  // register state
  // ctrl and irq keep only their implemented bits; reads zero-extend them
  logic [CTRL_W-1:0]  ctrl_reg;
  logic [CTRL_W-1:0]  ctrl_next;
  logic [IRQ_W-1:0]   irq_reg;
  logic [IRQ_W-1:0]   irq_next;
  logic [31:0]        rdata_reg;
  logic               ack_reg;

  // synchronisers, first stage feeds only the second
  // ext_d_reg is a third stage used only as the edge detector's memory;
  // pin edges closer together than about one clock can be lost
  logic gate_s1_reg;
  logic gate_s2_reg;
  logic ext_s1_reg;
  logic ext_s2_reg;
  logic ext_d_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gate_s1_reg <= 1'b0;
      gate_s2_reg <= 1'b0;
      ext_s1_reg  <= 1'b0;
      ext_s2_reg  <= 1'b0;
      ext_d_reg   <= 1'b0;
    end else begin
      gate_s1_reg <= gate_input_pin_i;
      gate_s2_reg <= gate_s1_reg;
      ext_s1_reg  <= ext_count_pin_i;
      ext_s2_reg  <= ext_s1_reg;
      ext_d_reg   <= ext_s2_reg;
    end
  end

  // 8-bit timer wrap pulse
  // the neighbour count arrives on our clock, so only its previous value is kept;
  // a count that skipped across ff to 00 would miss a pulse
  logic [PRE_W-1:0] t8_prev_reg;
  logic             t8_pulse_reg;
  wire  logic       t8_wrap = (t8_prev_reg == PRE_MAX) && (t8_count_i == PRE_ZERO);

  // one-cycle low-to-high pulse per wrap
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      t8_prev_reg  <= PRE_ZERO;
      t8_pulse_reg <= 1'b0;
    end else begin
      t8_prev_reg  <= t8_count_i;
      t8_pulse_reg <= t8_wrap;
    end
  end

  // gate processing
  // every control bit gets a named wire so the gate path reads like the mode table
  wire logic on_bit   = ctrl_reg[CTRL_ON];
  wire logic cs_ext   = ctrl_reg[CTRL_CS];
  wire logic sync_n   = ctrl_reg[CTRL_SYNCN];
  wire logic ge_bit   = ctrl_reg[CTRL_GE];
  wire logic pol_bit  = ctrl_reg[CTRL_POL];
  wire logic tm_bit   = ctrl_reg[CTRL_TM];
  wire logic spm_bit  = ctrl_reg[CTRL_SPM];
  wire logic arm_bit  = ctrl_reg[CTRL_ARM];
  wire logic src_bit  = ctrl_reg[CTRL_SRC];

  // source select then polarity; after polarity a rising edge is the incrementing edge
  wire logic src_raw  = src_bit ? t8_pulse_reg : gate_s2_reg;
  wire logic src_pol  = pol_bit ? src_raw : ~src_raw;

  logic src_pol_d_reg;
  logic tff_reg;
  logic tog_d_reg;
  logic window_reg;
  logic gls_reg;

  wire logic src_rise = src_pol & ~src_pol_d_reg;
  // toggle output lags one cycle behind the edge; harmless since counting follows it
  wire logic tog      = tm_bit ? tff_reg : src_pol;
  wire logic tog_rise = tog & ~tog_d_reg;
  wire logic tog_fall = ~tog & tog_d_reg;
  wire logic sp_start = spm_bit & arm_bit & tog_rise;
  wire logic sp_done  = spm_bit & window_reg & tog_fall;
  // with single pulse on, only the armed window passes the gate
  wire logic gate_val = spm_bit ? (tog & (window_reg | sp_start)) : tog;
  // the event flag is set at the same edge at which the gate level status falls
  wire logic gls_fall = gls_reg & ~gate_val;

  // toggle flip-flop, single-pulse window and gate value
  // the toggle flip-flop is held clear while toggle mode is off, so the measured edge is known
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      src_pol_d_reg <= 1'b0;
      tff_reg       <= 1'b0;
      tog_d_reg     <= 1'b0;
      window_reg    <= 1'b0;
      gls_reg       <= 1'b0;
    end else begin
      src_pol_d_reg <= src_pol;
      if (!tm_bit) begin
        tff_reg <= 1'b0;
      end else if (src_rise) begin
        tff_reg <= ~tff_reg;
      end
      tog_d_reg <= tog;
      if (!spm_bit || sp_done) begin
        window_reg <= 1'b0;
      end else if (sp_start) begin
        window_reg <= 1'b1;
      end
      gls_reg <= gate_val;
    end
  end

  // count enable
  // internal mode counts every clock; external mode counts each synchronised pin rise
  wire logic ext_tick   = ext_s2_reg & ~ext_d_reg;
  // in sleep only the asynchronous external mode keeps counting
  // with sync_disable_n clear the count freezes in sleep, though the oscillator runs on
  wire logic sleep_ok   = ~sleep_i | (cs_ext & sync_n);
  wire logic tick       = (cs_ext ? ext_tick : 1'b1) & sleep_ok;
  wire logic gate_ok    = ~ge_bit | gate_val;
  wire logic count_inc  = on_bit & tick & gate_ok;

  // wishbone decode
  // a request is taken only while ack is low, so a strobe still held in its ack cycle is not taken again there;
  // only the exact offsets hit, every other address reads zero
  wire logic        req       = wb_cyc_i & wb_stb_i & ~ack_reg;
  wire logic        wr        = req & wb_we_i;
  wire logic        hit_ctrl  = (wb_adr_i == OFF_CTRL);
  wire logic        hit_irq   = (wb_adr_i == OFF_IRQ);
  wire logic        hit_count = (wb_adr_i == OFF_COUNT);
  wire logic [31:0] byte_mask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  wire logic        wr_ctrl   = wr & hit_ctrl;
  wire logic        wr_irq    = wr & hit_irq;
  wire logic        wr_count  = wr & hit_count;

  wire logic [31:0] ctrl_wide  = {{(32-CTRL_W){1'b0}}, ctrl_reg};
  wire logic [31:0] irq_wide   = {{(32-IRQ_W){1'b0}}, irq_reg};
  wire logic [31:0] ctrl_merge = (wb_dat_i & byte_mask) | (ctrl_wide & ~byte_mask);
  wire logic [31:0] irq_merge  = (wb_dat_i & byte_mask) | (irq_wide & ~byte_mask);
  wire logic [31:0] cnt_wide   = {{(32-COUNT_W){1'b0}}, cnt_bus.count};
  wire logic [31:0] cnt_merge  = (wb_dat_i & byte_mask) | (cnt_wide & ~byte_mask);

  wire logic [31:0] rd_irq     = irq_wide | ({31'h00000000, gls_reg} << IRQ_GLS);
  // unmapped addresses answer with zero and ignore writes
  wire logic [31:0] rd_mux     = hit_ctrl  ? ctrl_wide :
                                 hit_irq   ? rd_irq    :
                                 hit_count ? cnt_wide  : 32'h00000000;

  // control next value: software writes, then hardware clears the arm bit
  // clearing single-pulse enable leaves the arm bit alone; software clears both
  always_comb begin
    ctrl_next = ctrl_reg;
    if (wr_ctrl) begin
      ctrl_next = ctrl_merge[CTRL_W-1:0];
    end
    // a software set of the arm bit in the same cycle wins over the self-clear
    if (sp_done && !(wr_ctrl && ctrl_merge[CTRL_ARM])) begin
      ctrl_next[CTRL_ARM] = 1'b0;
    end
  end

  // flags: software writes zero to clear, hardware set wins over the clear
  // a write of one keeps a flag, so one flag can be cleared without racing the other
  always_comb begin
    irq_next = irq_reg;
    if (wr_irq) begin
      irq_next = irq_merge[IRQ_W-1:0];
      irq_next[IRQ_ROLL_F] = irq_reg[IRQ_ROLL_F] & irq_merge[IRQ_ROLL_F];
      irq_next[IRQ_GATE_F] = irq_reg[IRQ_GATE_F] & irq_merge[IRQ_GATE_F];
    end
    if (cnt_bus.wrap) begin
      irq_next[IRQ_ROLL_F] = 1'b1;
    end
    // set regardless of gate_counting_enable
    if (gls_fall) begin
      irq_next[IRQ_GATE_F] = 1'b1;
    end
  end

  // counter hookup
  assign cnt_bus.inc      = count_inc;
  assign cnt_bus.load     = wr_count;
  assign cnt_bus.load_val = cnt_merge[COUNT_W-1:0];

  // register file and bus answer
  // read data is captured only on a taken request, so it holds until the next one
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_reg  <= CTRL_RST;
      irq_reg   <= IRQ_RST;
      ack_reg   <= 1'b0;
      rdata_reg <= 32'h00000000;
    end else begin
      ctrl_reg  <= ctrl_next;
      irq_reg   <= irq_next;
      ack_reg   <= req;
      if (req) begin
        rdata_reg <= rd_mux;
      end
    end
  end

  // interrupt, wake and oscillator outputs
  // built from next values so each output flop lines up with the register it mirrors;
  // this costs a little logic in front of the flops but saves a cycle of lag
  wire logic roll_f   = irq_next[IRQ_ROLL_F];
  wire logic roll_en  = ctrl_next[CTRL_ON] & irq_next[IRQ_ROLL_IE] & irq_next[IRQ_PERI_IE];
  wire logic roll_irq = roll_f & roll_en & irq_next[IRQ_GLOB_IE];
  wire logic gate_irq = irq_next[IRQ_GATE_F] & irq_next[IRQ_GATE_IE];
  wire logic wake     = sleep_i & roll_f & roll_en;
  // oscillator follows the clock select only, never sleep or sync_disable_n
  wire logic osc_run  = ctrl_next[CTRL_CS];

  // output flops; rollover_irq_o, gate_irq_o, wake_o and osc_run_o come straight from these
  logic roll_irq_reg;
  logic gate_irq_reg;
  logic wake_reg;
  logic osc_run_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      roll_irq_reg <= 1'b0;
      gate_irq_reg <= 1'b0;
      wake_reg     <= 1'b0;
      osc_run_reg  <= 1'b0;
    end else begin
      roll_irq_reg <= roll_irq;
      gate_irq_reg <= gate_irq;
      wake_reg     <= wake;
      osc_run_reg  <= osc_run;
    end
  end

  assign wb_dat_o       = rdata_reg;
  assign wb_ack_o       = ack_reg;
  assign rollover_irq_o = roll_irq_reg;
  assign gate_irq_o     = gate_irq_reg;
  assign wake_o         = wake_reg;
  assign osc_run_o      = osc_run_reg;
  assign gate_level_o   = gls_reg;
endmodule
`default_nettype wire

// ### shared/tg_cnt_if.sv
// Purpose: carrier between the gate controller and the count pair
// Assumes: both ends on the same clock
// Notes:   wrap is a one-cycle pulse from the counter
`timescale 1ns/1ps
`default_nettype none
interface tg_cnt_if #(parameter int unsigned WIDTH = 16);
  logic             inc;
  logic             load;
  logic [WIDTH-1:0] load_val;
  logic [WIDTH-1:0] count;
  logic             wrap;

  modport ctl (output inc, output load, output load_val, input count, input wrap);
  modport cnt (input inc, input load, input load_val, output count, output wrap);
endinterface
`default_nettype wire

// ### shared/tg_pkg.sv
// Purpose: shared constants for the timer gate and interrupt block
// Assumes: 32-bit classic Wishbone register bus, byte addressed
// Notes:   one register per aligned word; unlisted bits read as zero, except flag and enable register bits 7:2, which read back as written
package tg_pkg;

  localparam int unsigned CLK_HZ        = 40_000_000;
  localparam int unsigned COUNT_W       = 16;
  localparam int unsigned PRE_W         = 8;

  // register byte offsets
  localparam logic [7:0] OFF_CTRL       = 8'h00;
  localparam logic [7:0] OFF_IRQ        = 8'h04;
  localparam logic [7:0] OFF_COUNT      = 8'h08;

  // control register fields
  localparam int unsigned CTRL_W        = 9;
  localparam int unsigned CTRL_ON       = 0;  // counter_on
  localparam int unsigned CTRL_CS       = 1;  // count_clock_select, 1 = external count pin
  localparam int unsigned CTRL_SYNCN    = 2;  // sync_disable_n
  localparam int unsigned CTRL_GE       = 3;  // gate_counting_enable
  localparam int unsigned CTRL_POL      = 4;  // gate_polarity, 1 = active high
  localparam int unsigned CTRL_TM       = 5;  // gate_toggle_enable
  localparam int unsigned CTRL_SPM      = 6;  // gate_single_pulse_enable
  localparam int unsigned CTRL_ARM      = 7;  // gate_pulse_arm
  localparam int unsigned CTRL_SRC      = 8;  // gate source, 1 = 8-bit timer overflow
  localparam logic [CTRL_W-1:0] CTRL_RST = 9'h000;

  // flag and enable register fields
  localparam int unsigned IRQ_W         = 12;
  localparam int unsigned IRQ_ROLL_F    = 0;  // rollover_flag
  localparam int unsigned IRQ_GATE_F    = 1;  // gate_event_flag
  localparam int unsigned IRQ_ROLL_IE   = 8;  // rollover_irq_enable
  localparam int unsigned IRQ_GATE_IE   = 9;  // gate_event_irq_enable
  localparam int unsigned IRQ_PERI_IE   = 10; // peripheral_irq_enable
  localparam int unsigned IRQ_GLOB_IE   = 11; // global_irq_enable
  localparam int unsigned IRQ_GLS       = 16; // gate_level_status, read only
  localparam logic [IRQ_W-1:0] IRQ_RST  = 12'h000;

  localparam logic [COUNT_W-1:0] COUNT_RST = 16'h0000;
  localparam logic [PRE_W-1:0]   PRE_MAX   = 8'hff;
  localparam logic [PRE_W-1:0]   PRE_ZERO  = 8'h00;

endpackage

// ### test/tb_timer1_gate_and_interrupt.sv
// Purpose: self-checking bench for the gate and interrupt block
// Assumes: reads queue their expectation; a monitor compares at ack
// Notes:   counts are exact since gate latency is a pure delay
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checks++; if ((e) !== (g)) begin bad_count++; \
  $display("ERROR %s exp %h got %h", n, e, g); end end
module tb_timer1_gate_and_interrupt;
  logic clk = 1'b0;
  logic rst, cyc, stb, we, lvl, ext, slp, run, pin, ack, ri, gi, wk, osc, gl;
  logic [7:0]  adr, t8;
  logic [3:0]  sel;
  logic [31:0] dat, rdat, me, mm, v;
  logic [31:0] seed = 32'h0000d966;
  logic [31:0] qe[$];
  logic [31:0] qm[$];
  int checks = 0;
  int bad_count = 0;
  always #12.5 clk = ~clk;
  tg_gate_top i_tg_gate_top (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .gate_input_pin_i(pin), .ext_count_pin_i(ext), .t8_count_i(t8), .sleep_i(slp),
    .rollover_irq_o(ri), .gate_irq_o(gi), .wake_o(wk), .osc_run_o(osc), .gate_level_o(gl));
  tg_partner i_tg_partner (.clk_i(clk), .rst_i(rst), .run_i(run), .lvl_i(lvl), .gate_o(pin), .cnt_o(t8));
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // one classic cycle; request held until ack is sampled
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d, input logic [3:0] s);
    @(posedge clk);
    {cyc, stb, we, adr, dat, sel} <= {2'b11, w, a, d, s};
    do @(posedge clk); while (ack !== 1'b1);
    {cyc, stb} <= 2'b00;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hf);
    bus(a, 1'b1, d, s);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = 32'hffffffff);
    qe.push_back(e & m);
    qm.push_back(m);
    bus(a, 1'b0, 32'h0, 4'hf);
  endtask
  task automatic pulse(input int n);
    lvl <= 1'b1;
    repeat (n) @(posedge clk);
    lvl <= 1'b0;
    repeat (n + 6) @(posedge clk);
  endtask
  task automatic ext_run(input int n);
    repeat (n) begin
      ext <= ~ext;
      repeat (2) @(posedge clk);
    end
  endtask
  task automatic final_report();
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // read monitor: oldest expectation against the data at ack
  always @(posedge clk) begin
    if (ack === 1'b1 && we === 1'b0) begin
      me = qe.pop_front();
      mm = qm.pop_front();
      `CHK("read data", me, rdat & mm)
    end
  end
  // watchdog; the run needs about a thousand cycles
  initial begin
    repeat (6000) @(posedge clk);
    bad_count++;
    final_report();
  end
  initial begin
    {rst, cyc, stb, we, lvl, ext, slp, run} <= 8'h80;
    {adr, sel, dat} <= 44'h0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rd(8'h00, 32'h0);
    rd(8'h04, 32'h0, 32'hfff);
    rd(8'h08, 32'h0);
    v = xs() & 32'h1de;
    wr(8'h00, v);
    wr(8'h00, 32'h0, 4'b0010);
    rd(8'h00, v & 32'hff);
    wr(8'h0c, 32'hffffffff);
    rd(8'h0c, 32'h0);
    v = xs();
    wr(8'h08, v);
    rd(8'h08, v, 32'hffff);
    // rollover with all enables, then global off, then flag clear
    wr(8'h00, 32'h0);
    wr(8'h08, 32'hfff0);
    wr(8'h04, 32'hf00);
    wr(8'h00, 32'h1);
    repeat (30) @(posedge clk);
    rd(8'h04, 32'hf01, 32'hfff);
    `CHK("rollover irq", 1'b1, ri)
    wr(8'h00, 32'h0);
    wr(8'h04, 32'h701);
    repeat (3) @(posedge clk);
    `CHK("rollover irq", 1'b0, ri)
    rd(8'h04, 32'h701, 32'hfff);
    wr(8'h04, 32'h0);
    rd(8'h04, 32'h0, 32'hfff);
    // gate level and gate event with gating off
    wr(8'h00, 32'h10);
    repeat (6) @(posedge clk);
    wr(8'h04, 32'h200);
    rd(8'h04, 32'h200);
    lvl <= 1'b1;
    repeat (8) @(posedge clk);
    `CHK("gate level", 1'b1, gl)
    rd(8'h04, 32'h10200);
    lvl <= 1'b0;
    repeat (8) @(posedge clk);
    `CHK("gate level", 1'b0, gl)
    rd(8'h04, 32'h202);
    `CHK("gate irq", 1'b1, gi)
    wr(8'h04, 32'h2);
    repeat (3) @(posedge clk);
    `CHK("gate irq", 1'b0, gi)
    // gated counting, then single pulse, then toggle with single pulse
    wr(8'h00, 32'h19);
    wr(8'h08, 32'h0);
    pulse(10);
    rd(8'h08, 32'd10, 32'hffff);
    wr(8'h08, 32'h0);
    wr(8'h00, 32'hd9);
    pulse(10);
    pulse(10);
    rd(8'h08, 32'd10, 32'hffff);
    rd(8'h00, 32'h59);
    wr(8'h08, 32'h0);
    wr(8'h00, 32'hf9);
    repeat (3) pulse(10);
    rd(8'h08, 32'd26, 32'hffff);
    rd(8'h00, 32'h79);
    wr(8'h00, 32'h19);
    // 8-bit timer wraps as gate source: one count per wrap
    wr(8'h00, 32'h119);
    wr(8'h08, 32'h0);
    wr(8'h04, 32'h0);
    run <= 1'b1;
    repeat (520) @(posedge clk);
    run <= 1'b0;
    repeat (6) @(posedge clk);
    rd(8'h08, 32'd2, 32'hffff);
    rd(8'h04, 32'h2, 32'h2);
    // sleep: external counting wraps and wakes, then sync off stops it
    wr(8'h00, 32'h7);
    wr(8'h08, 32'hfffe);
    wr(8'h04, 32'h500);
    slp <= 1'b1;
    ext_run(6);
    repeat (8) @(posedge clk);
    `CHK("wake", 1'b1, wk)
    `CHK("osc run", 1'b1, osc)
    `CHK("rollover irq", 1'b0, ri)
    wr(8'h00, 32'h3);
    wr(8'h08, 32'h10);
    ext_run(6);
    rd(8'h08, 32'h10, 32'hffff);
    slp <= 1'b0;
    // let the monitor take the last read before the verdict
    repeat (2) @(posedge clk);
    final_report();
  end
endmodule
`default_nettype wire

// ### test/tg_gate_top_assertions.sv
// Purpose: port-level checks of the gate and interrupt block
// Assumes: classic single-cycle bus master, one clock
// Notes:   enables are mirrored at ack, one edge after the design takes them
`timescale 1ns/1ps
`default_nettype none
module tg_gate_top_assertions
  import tg_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [31:0] wb_dat_o,
  input  wire logic        wb_ack_o,
  input  wire logic        sleep_i,
  input  wire logic        rollover_irq_o,
  input  wire logic        gate_irq_o,
  input  wire logic        wake_o,
  input  wire logic        osc_run_o,
  input  wire logic        gate_level_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // request decode
  wire logic req  = wb_cyc_i && wb_stb_i;
  wire logic wr_c = req && wb_we_i && wb_adr_i == OFF_CTRL;
  wire logic wr_q = req && wb_we_i && wb_adr_i == OFF_IRQ;
  logic       on_reg;
  logic       gie_reg;
  logic [2:0] en_reg; // global, peripheral, rollover
  // mirror of the enables, only what the irq outputs depend on
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      on_reg  <= 1'b0;
      gie_reg <= 1'b0;
      en_reg  <= 3'h0;
    end else if (wb_ack_o) begin
      if (wr_c && wb_sel_i[0])
        on_reg <= wb_dat_i[CTRL_ON];
      if (wr_q && wb_sel_i[1])
        gie_reg <= wb_dat_i[IRQ_GATE_IE];
      if (wr_q && wb_sel_i[1])
        en_reg <= {wb_dat_i[IRQ_GLOB_IE], wb_dat_i[IRQ_PERI_IE], wb_dat_i[IRQ_ROLL_IE]};
    end
  end
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
  ack_answer_a: assert property (req && !wb_ack_o |=> wb_ack_o) else $error("request not answered");
  unmapped_zero_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i > OFF_COUNT |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  osc_source_a: assert property ($changed(osc_run_o) |-> $past(wr_c) || $past(wr_c, 2))
    else $error("oscillator changed without control write");
  wake_cause_a: assert property (wake_o |-> $past(sleep_i) && on_reg && en_reg[1] && en_reg[0])
    else $error("wake without sleep and enables");
  roll_irq_a: assert property (rollover_irq_o |-> on_reg && (&en_reg))
    else $error("rollover irq without all enables");
  gate_irq_a: assert property (gate_irq_o |-> gie_reg) else $error("gate irq while masked");
  gate_event_a: assert property ($fell(gate_level_o) && gie_reg |-> ##[1:3] gate_irq_o)
    else $error("gate fall did not raise gate irq");
  cover property (rollover_irq_o);
  cover property (wake_o);
  cover property ($fell(gate_level_o) && gie_reg);
endmodule
bind tg_gate_top tg_gate_top_assertions i_tg_gate_top_assertions (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .sleep_i(sleep_i), .rollover_irq_o(rollover_irq_o), .gate_irq_o(gate_irq_o),
  .wake_o(wake_o), .osc_run_o(osc_run_o), .gate_level_o(gate_level_o));
`default_nettype wire

// ### test/tg_partner.sv
// Purpose: neighbour model for the gate block: gate source pin and the 8-bit timer
// Assumes: same clock as the block; bench commands levels and running
// Notes:   pin follows the command one cycle late, like a slow external source
`timescale 1ns/1ps
`default_nettype none
module tg_partner (
  input  wire logic                     clk_i,
  input  wire logic                     rst_i,
  input  wire logic                     run_i,
  input  wire logic                     lvl_i,
  output logic                          gate_o,
  output logic [tg_pkg::PRE_W-1:0]      cnt_o
);
  // the 8-bit timer wraps ff to 00 on its own; the gate pin lags its command
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_o  <= 8'h00;
      gate_o <= 1'b0;
    end else begin
      if (run_i)
        cnt_o <= cnt_o + 8'h01;
      gate_o <= lvl_i;
    end
  end
endmodule
`default_nettype wire
